//--- include/umprx_pkg.sv
// constants for the modem pin, read strobe and receive dma block
package umprx_pkg;
    // modem status bit positions
    localparam int MSR_RING_LEVEL_POS = 6;
    localparam int MSR_RING_END_POS = 2;
    // modem control bit positions
    localparam int MCR_RTS_POS = 1;
    localparam int MCR_LOOP_POS = 4;
    // fifo control bit positions
    localparam int FCR_ENABLE_POS = 0;
    localparam int FCR_DMA_POS = 3;
    // ratio of receiver sample clock to baud rate
    localparam int RX_OVERSAMPLE = 16;
    // reset values
    localparam logic RESET_RTS_N = 1'h1;
    localparam logic RESET_RECEIVE_DMA_REQUEST_N = 1'h1;
endpackage

//--- rtl/umprx_core.sv
// modem pin status, rts control, read strobes and receive dma request
`timescale 1ns/1ps
// How it works
// - receiver timed by 16x baud sample clock
// - either read strobe reads while chip selected
// - ring level shown in modem status bit6
// - ring low-to-high sets end flag bit2
// - enabled modem interrupt on ring rising edge
// - auto rts threshold forces rts inactive
// - fifo mode dma type from control bit3
// - fifos off means dma mode zero only
// - mode zero: ready low while data held
// - mode one: low at trigger, high empty
module umprx_core
    import umprx_pkg::*;
(
    input wire logic clk_i,            // block clock
    input wire logic rst_i,            // master reset, sync high
    input wire logic ce_i,             // clock enable
    input wire logic rx_sample_clk_i,  // 16x baud sample clock pin
    output logic rx_sample_tick_o,     // one pulse per sample clock rise
    input wire logic chip_select_i,    // chip selected, decoded
    input wire logic host_read_strobe_n_i, // active-low read strobe
    input wire logic host_read_strobe_i,   // active-high read strobe
    input wire logic msr_select_i,     // read targets modem status
    output logic read_active_o,        // a register read in progress
    output logic [7:0] msr_data_o,     // ring part of modem status
    input wire logic call_alert_n_i,   // ring alert pin, active low
    input wire logic modem_irq_en_i,   // modem status interrupt enable
    output logic modem_irq_o,          // modem status interrupt request
    input wire logic [7:0] modem_control_reg_i, // modem control bits
    input wire logic auto_rts_en_i,    // automatic rts mode
    input wire logic rx_threshold_i,   // rx fifo at rts threshold
    output logic rts_n_o,              // request to send, active low
    input wire logic [7:0] fifo_control_reg_i, // fifo control bits
    input wire logic rx_fifo_empty_i,  // fifo and holding reg empty
    input wire logic rx_trigger_i,     // rx trigger level reached
    input wire logic rx_timeout_i,     // rx time-out event
    output logic receive_dma_request_n_o // rx ready, active low
);
    // all block state in one struct
    typedef struct packed {
        logic sclk_s1;      // sample clock sync stage 1
        logic sclk_s2;      // sample clock sync stage 2
        logic sclk_last;    // previous synced sample clock
        logic tick;         // sample clock rising pulse
        logic ri_s1;        // ring sync stage 1
        logic ri_s2;        // ring sync stage 2
        logic ri_last;      // previous synced ring pin
        logic cs_s1;        // chip select sync stage 1
        logic cs_s2;        // chip select sync stage 2
        logic rdn_s1;       // active-low strobe sync stage 1
        logic rdn_s2;       // active-low strobe sync stage 2
        logic rdh_s1;       // active-high strobe sync stage 1
        logic rdh_s2;       // active-high strobe sync stage 2
        logic rd_last;      // previous combined read
        logic ring_end;     // trailing edge ring flag
        logic irq;          // interrupt request
        logic [7:0] msr;    // captured status data
        logic rts_n;        // rts pin level
        logic rdy_n;        // rx ready level
    } umprx_state_type;

    umprx_state_type state_reg;
    umprx_state_type state_next;

    // combined read from synced pins, either polarity, while selected
    logic read_sync;
    assign read_sync = state_reg.cs_s2 &
        (~state_reg.rdn_s2 | state_reg.rdh_s2);

    // helper terms
    logic ring_rise;      // ring went low to high (pin level)
    logic msr_read_edge;  // start of a modem status read
    logic fifo_on;
    logic dma_mode1;
    always_comb begin
        // ring pin inactive-high edge: low to high on the pin
        ring_rise = state_reg.ri_s2 & ~state_reg.ri_last;
        msr_read_edge = read_sync & ~state_reg.rd_last &
            msr_select_i;
        fifo_on = fifo_control_reg_i[FCR_ENABLE_POS];
        // mode one only with fifos on
        dma_mode1 = fifo_on &
            fifo_control_reg_i[FCR_DMA_POS];
    end

    // next state
    always_comb begin
        state_next = state_reg;
        // synchronisers
        state_next.sclk_s1 = rx_sample_clk_i;
        state_next.sclk_s2 = state_reg.sclk_s1;
        state_next.sclk_last = state_reg.sclk_s2;
        // receiver timing tick from 16x sample clock
        state_next.tick = state_reg.sclk_s2 &
            ~state_reg.sclk_last;
        state_next.ri_s1 = call_alert_n_i;
        state_next.ri_s2 = state_reg.ri_s1;
        state_next.ri_last = state_reg.ri_s2;
        // read pins synchronised one by one, combined only after
        state_next.cs_s1 = chip_select_i;
        state_next.cs_s2 = state_reg.cs_s1;
        state_next.rdn_s1 = host_read_strobe_n_i;
        state_next.rdn_s2 = state_reg.rdn_s1;
        state_next.rdh_s1 = host_read_strobe_i;
        state_next.rdh_s2 = state_reg.rdh_s1;
        state_next.rd_last = read_sync;
        // read clears flag, a new edge wins
        if (ring_rise) begin
            state_next.ring_end = 1'h1;
        end else if (msr_read_edge) begin
            state_next.ring_end = 1'h0;
        end
        // interrupt on ring edge, cleared by status read
        if (ring_rise && modem_irq_en_i) begin
            state_next.irq = 1'h1;
        end else if (msr_read_edge || !modem_irq_en_i) begin
            state_next.irq = 1'h0;
        end
        // status data captured when a read starts
        if (msr_read_edge) begin
            state_next.msr = 8'h00;
            state_next.msr[MSR_RING_LEVEL_POS] =
                ~state_reg.ri_s2;
            state_next.msr[MSR_RING_END_POS] =
                state_reg.ring_end | ring_rise;
        end
        // rts pin
        if (modem_control_reg_i[MCR_LOOP_POS]) begin
            state_next.rts_n = 1'h1;
        end else if (auto_rts_en_i && rx_threshold_i) begin
            state_next.rts_n = 1'h1;
        end else begin
            state_next.rts_n =
                ~modem_control_reg_i[MCR_RTS_POS];
        end
        // receive dma request
        if (!dma_mode1) begin
            state_next.rdy_n = rx_fifo_empty_i;
        end else if (rx_fifo_empty_i) begin
            state_next.rdy_n = 1'h1;
        end else if (rx_trigger_i || rx_timeout_i) begin
            state_next.rdy_n = 1'h0;
        end
    end

    // registers, frozen while clock enable low
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state_reg <= '0;
            state_reg.sclk_s1 <= 1'h0;
            state_reg.ri_s1 <= 1'h1;
            state_reg.ri_s2 <= 1'h1;
            state_reg.ri_last <= 1'h1;
            state_reg.rdn_s1 <= 1'h1;
            state_reg.rdn_s2 <= 1'h1;
            state_reg.rts_n <= RESET_RTS_N;
            state_reg.rdy_n <= RESET_RECEIVE_DMA_REQUEST_N;
        end else if (ce_i) begin
            state_reg <= state_next;
        end
    end

    // outputs
    assign rx_sample_tick_o = state_reg.tick;
    assign read_active_o = read_sync;
    assign msr_data_o = state_reg.msr;
    assign modem_irq_o = state_reg.irq;
    assign rts_n_o = state_reg.rts_n;
    assign receive_dma_request_n_o = state_reg.rdy_n;

    // ring edge sets flag next cycle
    ring_flag_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ce_i && ring_rise |=> state_reg.ring_end)
        else $error("ring end flag not set");

    // enabled edge raises interrupt
    ring_irq_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ce_i && ring_rise && modem_irq_en_i |=> modem_irq_o)
        else $error("modem interrupt not raised");

    // read without edge clears flag
    flag_clear_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ce_i && msr_read_edge && !ring_rise |=> !state_reg.ring_end)
        else $error("ring flag not cleared by read");

    // loop mode forces rts inactive
    loop_rts_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ce_i && modem_control_reg_i[MCR_LOOP_POS] |=> rts_n_o)
        else $error("rts active in loop mode");

    // auto rts throttle
    auto_rts_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ce_i && auto_rts_en_i && rx_threshold_i |=> rts_n_o)
        else $error("auto rts did not throttle");

    // mode zero tracks data held
    mode_zero_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ce_i && !dma_mode1 |=>
            receive_dma_request_n_o == $past(rx_fifo_empty_i))
        else $error("mode zero ready wrong");

    // mode one holds low until empty
    mode_one_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ce_i && dma_mode1 && !receive_dma_request_n_o &&
            !rx_fifo_empty_i |=> !receive_dma_request_n_o)
        else $error("mode one ready released early");

    // fifos off never uses mode one
    fifo_off_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ce_i && !fifo_on && !rx_fifo_empty_i |=>
            !receive_dma_request_n_o)
        else $error("legacy mode ready wrong");

    // status read shows ring level
    ring_level_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ce_i && msr_read_edge |=>
            msr_data_o[MSR_RING_LEVEL_POS] == !$past(state_reg.ri_s2))
        else $error("ring level wrong in status");

    // sample clock rise makes a tick
    tick_rise_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ce_i && state_reg.sclk_s2 && !state_reg.sclk_last |=>
            rx_sample_tick_o)
        else $error("sample tick missing");

    // status holds between reads
    msr_hold_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ce_i && !msr_select_i |=> msr_data_o == $past(msr_data_o))
        else $error("status changed without a read");

    // edge at the read start is reported
    edge_at_read_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ce_i && msr_read_edge && ring_rise |=>
            msr_data_o[MSR_RING_END_POS])
        else $error("ring edge lost at read");

    // flag holds while nothing happens
    flag_hold_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ce_i && !ring_rise && !msr_read_edge |=>
            state_reg.ring_end == $past(state_reg.ring_end))
        else $error("ring flag changed by itself");

    // disabled interrupt stays low
    irq_off_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ce_i && !modem_irq_en_i |=> !modem_irq_o)
        else $error("interrupt raised while disabled");

    // status read withdraws the interrupt
    irq_clear_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ce_i && msr_read_edge && !ring_rise |=> !modem_irq_o)
        else $error("interrupt kept after status read");

    // rts follows software outside loop and throttle
    rts_follow_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ce_i && !modem_control_reg_i[MCR_LOOP_POS] &&
            !(auto_rts_en_i && rx_threshold_i) |=>
            rts_n_o == !$past(modem_control_reg_i[MCR_RTS_POS]))
        else $error("rts does not follow control bit");

    // frozen clock enable holds rts
    rts_freeze_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        !ce_i |=> $stable(rts_n_o))
        else $error("rts moved while clock enable low");

    // fifo on, dma bit clear is mode zero
    mode_sel_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ce_i && fifo_control_reg_i[FCR_ENABLE_POS] &&
            !fifo_control_reg_i[FCR_DMA_POS] |=>
            receive_dma_request_n_o == $past(rx_fifo_empty_i))
        else $error("dma mode select ignored");

    // trigger or time-out raises the request
    one_set_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ce_i && dma_mode1 && !rx_fifo_empty_i &&
            (rx_trigger_i || rx_timeout_i) |=> !receive_dma_request_n_o)
        else $error("mode one ready not raised");

    // empty fifo releases the request
    one_empty_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ce_i && dma_mode1 && rx_fifo_empty_i |=> receive_dma_request_n_o)
        else $error("mode one ready not released");

    // no request without trigger or time-out
    one_idle_a: assert property (@(posedge clk_i)
        disable iff (rst_i)
        ce_i && dma_mode1 && receive_dma_request_n_o &&
            !rx_trigger_i && !rx_timeout_i |=> receive_dma_request_n_o)
        else $error("mode one ready raised early");
endmodule

//--- testbench/umprx_host.sv
// host model issuing modem status reads through either read strobe
`timescale 1ns/1ps
module umprx_host (
    input wire logic clk_i, // block clock
    output logic cs_o,      // chip select
    output logic rd_n_o,    // active-low read strobe
    output logic rd_o,      // active-high read strobe
    output logic msr_sel_o  // modem status address decode
);
    // idle: both strobes inactive, chip not selected
    initial begin
        cs_o = 1'h0;
        rd_n_o = 1'h1;
        rd_o = 1'h0;
        msr_sel_o = 1'h0;
    end
    // one read on the chosen strobe, held 4 cycles, then 4 idle
    task automatic read(input logic hi);
        @(posedge clk_i);
        #1;
        cs_o = 1'h1;
        msr_sel_o = 1'h1;
        if (hi) rd_o = 1'h1;
        else rd_n_o = 1'h0;
        repeat (4) @(posedge clk_i);
        #1;
        rd_o = 1'h0;
        rd_n_o = 1'h1;
        cs_o = 1'h0;
        repeat (4) @(posedge clk_i);
        #1;
    endtask
endmodule

//--- testbench/tb_top.sv
// self-checking bench for the modem pin and receive dma block
`timescale 1ns/1ps
module tb_top;
    import umprx_pkg::*;
    // one row: inputs, then expected {rts_n, dma_n}
    typedef struct packed {
        logic [7:0] modem_control_reg; logic [1:0] at; logic [7:0] fifo_control_reg;
        logic [2:0] ev; logic [1:0] ex;
    } umprx_row_type;
    logic clk = 1'h0, rst = 1'h1, sclk = 1'h0, ring_n = 1'h1, irq_en = 1'h0;
    logic cs, rdn, rd, msel, ract, irq, rts_n, dma_n, tick;
    logic aut = 1'h0, thr = 1'h0, emp = 1'h1, trg = 1'h0, tmo = 1'h0;
    logic [7:0] msr, modem_control_reg = 8'h00, fifo_control_reg = 8'h00;
    logic ce = 1'h1;
    int fail_count = 0, n_compared = 0, ticks = 0;
    // mode and flow-control table: {aut,thr}, {empty,trigger,timeout}
    umprx_row_type rows [11] = '{
        '{8'h02, 2'h0, 8'h00, 3'h0, 2'h0}, '{8'h00, 2'h0, 8'h00, 3'h4, 2'h3},
        '{8'h12, 2'h0, 8'h08, 3'h0, 2'h2}, '{8'h02, 2'h3, 8'h08, 3'h4, 2'h3},
        '{8'h02, 2'h3, 8'h09, 3'h0, 2'h3}, '{8'h02, 2'h2, 8'h09, 3'h2, 2'h0},
        '{8'h02, 2'h1, 8'h09, 3'h0, 2'h0}, '{8'h02, 2'h0, 8'h09, 3'h4, 2'h1},
        '{8'h02, 2'h0, 8'h09, 3'h1, 2'h0}, '{8'h02, 2'h0, 8'h01, 3'h4, 2'h1},
        '{8'h02, 2'h0, 8'h01, 3'h0, 2'h0}};
    umprx_host host (.clk_i(clk), .cs_o(cs), .rd_n_o(rdn), .rd_o(rd),
        .msr_sel_o(msel));
    umprx_core dut (.clk_i(clk), .rst_i(rst), .ce_i(ce),
        .rx_sample_clk_i(sclk), .rx_sample_tick_o(tick),
        .chip_select_i(cs), .host_read_strobe_n_i(rdn),
        .host_read_strobe_i(rd), .msr_select_i(msel),
        .read_active_o(ract), .msr_data_o(msr), .call_alert_n_i(ring_n),
        .modem_irq_en_i(irq_en), .modem_irq_o(irq),
        .modem_control_reg_i(modem_control_reg), .auto_rts_en_i(aut),
        .rx_threshold_i(thr), .rts_n_o(rts_n), .fifo_control_reg_i(fifo_control_reg),
        .rx_fifo_empty_i(emp), .rx_trigger_i(trg), .rx_timeout_i(tmo),
        .receive_dma_request_n_o(dma_n));
    // 250 MHz clock
    initial begin
        forever #2 clk = ~clk;
    end
    // sample tick counter
    always @(posedge clk) begin
        if (tick === 1'h1) ticks++;
    end
    // one comparison, counted
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // wait n cycles, land just after the edge
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // counts and verdict
    task automatic end_of_test();
        $display("Compared %0d, errors %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    // watchdog against a hang
    initial begin
        #20000;
        fail_count++;
        end_of_test();
    end
    // main sequence
    initial begin
        cyc(2);
        rst = 1'h0;
        check({rts_n, dma_n, irq, 5'h00}, 8'hC0);
        check(msr, 8'h00);
        foreach (rows[i]) begin
            {modem_control_reg, fifo_control_reg, aut, thr} = {rows[i].modem_control_reg, rows[i].fifo_control_reg, rows[i].at};
            {emp, trg, tmo} = rows[i].ev;
            cyc(2);
            check(8'({rts_n, dma_n}),
                8'(rows[i].ex));
        end
        ring_n = 1'h0;
        cyc(6);
        fork
            host.read(1'h0);
            begin
                cyc(3);
                check(8'(ract), 8'h01);
            end
        join
        check(msr, 8'h40);
        ring_n = 1'h1;
        cyc(6);
        check(8'(irq), 8'h00);
        host.read(1'h1);
        check(msr, 8'h04);
        host.read(1'h0);
        check(msr, 8'h00);
        irq_en = 1'h1;
        ring_n = 1'h0;
        cyc(6);
        ring_n = 1'h1;
        cyc(6);
        check(8'(irq), 8'h01);
        host.read(1'h0);
        check({irq, msr[6:0]}, 8'h04);
        // mid-run reset: outputs idle, no false ring edge after it
        rst = 1'h1;
        cyc(2);
        check({rts_n, dma_n, irq, 5'h00}, 8'hC0);
        check(msr, 8'h00);
        rst = 1'h0;
        cyc(2);
        check(8'({rts_n, dma_n}), 8'h00);
        host.read(1'h1);
        check(msr, 8'h00);
        // clock enable low freezes rts
        ce = 1'h0;
        modem_control_reg = 8'h00;
        cyc(2);
        check(8'(rts_n), 8'h00);
        ce = 1'h1;
        cyc(1);
        check(8'(rts_n), 8'h01);
        repeat (4) begin
            sclk = 1'h1;
            cyc(8);
            sclk = 1'h0;
            cyc(8);
        end
        check(8'(ticks), 8'h04);
        end_of_test();
    end
endmodule
